// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
    // ==========================================================
    // Clock, reset, stimulus and model state
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    tcb_pkg::tcb_sfr_req_s sreq = '0;
    tcb_pkg::tcb_bit_req_s breq = '0;
    logic a_inc = 1'b0;
    logic b_tick = 1'b0;
    logic c_tick = 1'b0;
    logic cap_pin = 1'b1;
    logic int_en = 1'b0;
    logic [7:0] rdata, a_high, ctl;
    logic [15:0] b_cnt, c_cnt, c_rl;
    logic s_hit, b_rdata, b_hit, irq, seen;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int m_cnt = 0;
    int m_ctl = 0;
    int m_rl = 0;
    int lo, hi, d;
    logic [7:0] addrs [5] = '{8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'h8A};

    tcb_timer_regs DUT (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .sfr_req_i(sreq), .sfr_rdata_o(rdata), .sfr_hit_o(s_hit),
        .bit_req_i(breq), .bit_rdata_o(b_rdata), .bit_hit_o(b_hit),
        .timer_a_high_inc_i(a_inc), .timer_b_tick_i(b_tick), .timer_c_tick_i(c_tick),
        .timer_c_capture_input_i(cap_pin), .timer_c_int_enable_i(int_en),
        .timer_a_count_high_o(a_high), .timer_b_count_o(b_cnt),
        .timer_c_count_o(c_cnt), .timer_c_reload_o(c_rl),
        .timer_c_control_o(ctl), .timer_c_irq_o(irq)
    );

    // Free-running clock
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    // Hang guard
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            summarize();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk_i);
        sreq.addr = a;
        sreq.wdata = v;
        sreq.wr = 1'b1;
        @(negedge core_clk_i);
        sreq.wr = 1'b0;
        if (a == 8'hC8) m_ctl = v & 8'hFD;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk_i);
        sreq.addr = a;
        sreq.rd = 1'b1;
        @(negedge core_clk_i);
        sreq.rd = 1'b0;
        chk({8'h00, rdata}, {8'h00, e});
        chk({15'h0000, s_hit}, {15'h0000, (a inside {8'h8B, 8'h8C, 8'h8D, 8'hC8})});
    endtask

    task automatic bw(input logic [2:0] n, input logic v);
        @(negedge core_clk_i);
        breq.bit_addr = 8'hC8 + {5'h00, n};
        breq.wdata = v;
        breq.wr = 1'b1;
        @(negedge core_clk_i);
        breq.wr = 1'b0;
        m_ctl[n] = v;
    endtask

    // Single-bit read of the control byte, with its address hit
    task automatic brd(input logic [7:0] a, input logic e);
        @(negedge core_clk_i);
        breq.bit_addr = a;
        breq.rd = 1'b1;
        @(negedge core_clk_i);
        breq.rd = 1'b0;
        chk({15'h0000, b_hit}, {15'h0000, (a[7:3] == 5'h19)});
        chk({15'h0000, b_rdata}, {15'h0000, e});
    endtask

    // Drive n timer C ticks and step the model alongside
    task automatic tick_c(input int n);
        @(negedge core_clk_i);
        c_tick = 1'b1;
        repeat (n) @(negedge core_clk_i);
        c_tick = 1'b0;
        for (int i = 0; i < n; i++) begin
            lo = m_cnt & 255;
            hi = m_cnt >> 8;
            if (m_ctl[3]) begin
                lo++;
                if (lo == 256) begin
                    lo = m_rl & 255;
                    m_ctl |= 64;
                end
                if (m_ctl[2]) hi++;
                if (hi == 256) begin
                    hi = m_rl >> 8;
                    m_ctl |= 128;
                end
                m_cnt = hi * 256 + lo;
            end else if (m_ctl[2]) begin
                if (lo == 255) m_ctl |= 64;
                m_cnt++;
                if (m_cnt == 65536) begin
                    m_cnt = m_rl;
                    m_ctl |= 128;
                end
            end
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(28));
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        reset_n_i = 1'b1;
        // Reset values and unmapped read
        for (int i = 0; i < 5; i++) rd(addrs[i], 8'h00);
        // Random byte write then read back
        for (int i = 0; i < 9; i++) begin
            d = $urandom & 255;
            wr(addrs[i % 3], d[7:0]);
            rd(addrs[i % 3], d[7:0]);
        end
        // Timer B carry and timer A high increment
        wr(8'h8B, 8'hFF);
        wr(8'h8D, 8'h12);
        wr(8'h8C, 8'hFF);
        @(negedge core_clk_i);
        b_tick = 1'b1;
        a_inc = 1'b1;
        @(negedge core_clk_i);
        b_tick = 1'b0;
        a_inc = 1'b0;
        chk(b_cnt, 16'h1300);
        rd(8'h8D, 8'h13);
        chk({8'h00, a_high}, 16'h0000);
        // Reserved bit stays zero; bit access to the run bit
        wr(8'hC8, 8'h02);
        rd(8'hC8, 8'h00);
        bw(3'h2, 1'b1);
        chk({8'h00, ctl}, 16'h0004);
        brd(8'hCA, 1'b1);
        brd(8'hD2, 1'b0);
        // Split mode with run off: only the low byte counts
        wr(8'hC8, 8'h08);
        tick_c(256);
        chk(c_cnt, m_cnt[15:0]);
        chk({8'h00, ctl}, m_ctl[15:0]);
        int_en = 1'b1;
        bw(3'h5, 1'b1);
        @(negedge core_clk_i);
        chk({15'h0000, irq}, 16'h0001);
        bw(3'h6, 1'b0);
        @(negedge core_clk_i);
        chk({15'h0000, irq}, 16'h0000);
        // Sixteen-bit mode up to full wrap
        wr(8'hC8, 8'h24);
        tick_c(300);
        chk(c_cnt, m_cnt[15:0]);
        chk({15'h0000, irq}, 16'h0001);
        tick_c(65236);
        chk(c_cnt, m_cnt[15:0]);
        repeat (10) @(negedge core_clk_i);
        chk({8'h00, ctl}, m_ctl[15:0]);
        chk({15'h0000, irq}, 16'h0001);
        wr(8'hC8, 8'h04);
        @(negedge core_clk_i);
        chk({15'h0000, irq}, 16'h0000);
        // Capture on a falling pin edge
        wr(8'hC8, 8'h14);
        tick_c(4660);
        seen = 1'b0;
        cap_pin = 1'b0;
        m_rl = m_cnt;
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk_i);
            if (irq === 1'b1) seen = 1'b1;
        end
        chk(c_rl, m_rl[15:0]);
        chk({15'h0000, seen}, 16'h0001);
        cap_pin = 1'b1;
        repeat (8) @(negedge core_clk_i);
        summarize();
    end
endmodule

// ===== tcb_params.svh
`ifndef TCB_PARAMS_SVH
`define TCB_PARAMS_SVH

// ==========================================================
// Special function addresses
`define TCB_ADDR_B_LOW 8'h8B
`define TCB_ADDR_A_HIGH 8'h8C
`define TCB_ADDR_B_HIGH 8'h8D
`define TCB_ADDR_C_CTRL 8'hC8

// Bit address group of the control byte (bit addresses C8..CF)
`define TCB_C_CTRL_BITS 5'h19

// ==========================================================
// Control byte field positions
`define TCB_C_HIGH_OVF 7
`define TCB_C_LOW_OVF 6
`define TCB_C_LOW_IE 5
`define TCB_C_CAP_EN 4
`define TCB_C_SPLIT 3
`define TCB_C_RUN 2
`define TCB_C_RSVD 1
`define TCB_C_XCLK 0

// ==========================================================
// Reset values and count limits
`define TCB_RST_BYTE 8'h00
`define TCB_RST_WORD 16'h0000
`define TCB_BYTE_MAX 8'hFF
`define TCB_WORD_MAX 16'hFFFF

`endif

// ===== tcb_pkg.sv
// ==========================================================
// Types shared by the timer byte block
package tcb_pkg;

    // Whole-byte special function access
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tcb_sfr_req_s;

    // Single-bit access to bit-addressable bytes
    typedef struct packed {
        logic [7:0] bit_addr;
        logic wr;
        logic rd;
        logic wdata;
    } tcb_bit_req_s;

endpackage

// ===== tcb_timer_regs.sv
`timescale 1ns/100ps
`include "tcb_params.svh"

// Summary of operation
// - Byte 0x8B holds timer B low count
// - Byte 0x8C holds timer A high count
// - Byte 0x8D holds timer B high count
// - Control at 0xC8, byte and bit access
// - High flag set on high wrap
// - High flag interrupts when enabled; software clears
// - Low flag set on low wrap; software clears
// - Low overflow interrupts when low enable set
// - Capture enable copies count on falling edge
// - Capture falling edge raises interrupt when enabled
// - Split runs two 8-bit reload timers
// - Run gates timer; in split, run gates high only
module tcb_timer_regs (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Special function byte access
    input wire tcb_pkg::tcb_sfr_req_s sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // Special function bit access
    input wire tcb_pkg::tcb_bit_req_s bit_req_i,
    output logic bit_rdata_o,
    output logic bit_hit_o,
    // Count ticks from the clock select logic
    input wire logic timer_a_high_inc_i,
    input wire logic timer_b_tick_i,
    input wire logic timer_c_tick_i,
    // Capture pin and interrupt enable
    input wire logic timer_c_capture_input_i,
    input wire logic timer_c_int_enable_i,
    // Timer state
    output logic [7:0] timer_a_count_high_o,
    output logic [15:0] timer_b_count_o,
    output logic [15:0] timer_c_count_o,
    output logic [15:0] timer_c_reload_o,
    output logic [7:0] timer_c_control_o,
    output logic timer_c_irq_o
);

    // ==========================================================
    // Storage
    logic [7:0] timer_b_count_low_reg;
    logic [7:0] timer_a_count_high_reg;
    logic [7:0] timer_b_count_high_reg;
    logic [7:0] timer_c_control_reg;
    logic [7:0] timer_c_control_next;
    logic [7:0] ctrl_sw;
    logic [15:0] timer_c_count_reg;
    logic [15:0] timer_c_reload_reg;
    logic [7:0] sfr_rdata_reg;
    logic bit_rdata_reg;
    logic cap_s1_reg;
    logic cap_s2_reg;
    logic cap_s3_reg;
    logic cap_level_reg;
    logic cap_event_reg;

    // ==========================================================
    // Decode
    logic wr_b_low;
    logic wr_a_high;
    logic wr_b_high;
    logic wr_ctrl;
    logic bit_sel;
    logic cap_fall;
    logic split;
    logic run;
    logic c_low_tick;
    logic c_high_tick;
    logic low_wrap;
    logic high_wrap;
    logic [7:0] rd_mux;

    // Byte write strobes per register
    assign wr_b_low = sfr_req_i.wr && (sfr_req_i.addr == `TCB_ADDR_B_LOW);
    assign wr_a_high = sfr_req_i.wr && (sfr_req_i.addr == `TCB_ADDR_A_HIGH);
    assign wr_b_high = sfr_req_i.wr && (sfr_req_i.addr == `TCB_ADDR_B_HIGH);
    assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == `TCB_ADDR_C_CTRL);
    assign bit_sel = (bit_req_i.bit_addr[7:3] == `TCB_C_CTRL_BITS);

    // Address hits
    assign sfr_hit_o = (sfr_req_i.addr == `TCB_ADDR_B_LOW)
        || (sfr_req_i.addr == `TCB_ADDR_A_HIGH)
        || (sfr_req_i.addr == `TCB_ADDR_B_HIGH)
        || (sfr_req_i.addr == `TCB_ADDR_C_CTRL);
    assign bit_hit_o = bit_sel;

    // ==========================================================
    // Timer A high byte: write loads, carry from low byte counts
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_a_count_high_reg <= `TCB_RST_BYTE;
        end else if (wr_a_high) begin
            timer_a_count_high_reg <= sfr_req_i.wdata;
        end else if (timer_a_high_inc_i) begin
            timer_a_count_high_reg <= timer_a_count_high_reg + 8'h01;
        end
    end

    // ==========================================================
    // Timer B: sixteen-bit count, each byte writable on its own
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_b_count_low_reg <= `TCB_RST_BYTE;
            timer_b_count_high_reg <= `TCB_RST_BYTE;
        end else begin
            if (wr_b_low) begin
                timer_b_count_low_reg <= sfr_req_i.wdata;
            end else if (timer_b_tick_i) begin
                timer_b_count_low_reg <= timer_b_count_low_reg + 8'h01;
            end
            if (wr_b_high) begin
                timer_b_count_high_reg <= sfr_req_i.wdata;
            end else if (timer_b_tick_i && (timer_b_count_low_reg == `TCB_BYTE_MAX)) begin
                timer_b_count_high_reg <= timer_b_count_high_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Capture pin synchroniser, change taken once stages 2 and 3 agree
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cap_s1_reg <= 1'b1;
            cap_s2_reg <= 1'b1;
            cap_s3_reg <= 1'b1;
            cap_level_reg <= 1'b1;
        end else begin
            cap_s1_reg <= timer_c_capture_input_i;
            cap_s2_reg <= cap_s1_reg;
            cap_s3_reg <= cap_s2_reg;
            if (cap_s2_reg == cap_s3_reg) begin
                cap_level_reg <= cap_s3_reg;
            end
        end
    end

    // Falling edge of the filtered level
    assign cap_fall = cap_level_reg && !cap_s2_reg && !cap_s3_reg;

    // ==========================================================
    // Timer C count enables and wraps
    assign split = timer_c_control_reg[`TCB_C_SPLIT];
    assign run = timer_c_control_reg[`TCB_C_RUN];
    assign c_low_tick = timer_c_tick_i && (split || run);
    assign c_high_tick = timer_c_tick_i && run && (split
        || (timer_c_count_reg[7:0] == `TCB_BYTE_MAX));
    assign low_wrap = c_low_tick && (timer_c_count_reg[7:0] == `TCB_BYTE_MAX);
    assign high_wrap = c_high_tick && (timer_c_count_reg[15:8] == `TCB_BYTE_MAX);

    // Count with auto-reload, per byte in split, whole word otherwise
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_c_count_reg <= `TCB_RST_WORD;
        end else if (split) begin
            if (low_wrap) begin
                timer_c_count_reg[7:0] <= timer_c_reload_reg[7:0];
            end else if (c_low_tick) begin
                timer_c_count_reg[7:0] <= timer_c_count_reg[7:0] + 8'h01;
            end
            if (high_wrap) begin
                timer_c_count_reg[15:8] <= timer_c_reload_reg[15:8];
            end else if (c_high_tick) begin
                timer_c_count_reg[15:8] <= timer_c_count_reg[15:8] + 8'h01;
            end
        end else if (c_low_tick) begin
            if (timer_c_count_reg == `TCB_WORD_MAX) begin
                timer_c_count_reg <= timer_c_reload_reg;
            end else begin
                timer_c_count_reg <= timer_c_count_reg + 16'h0001;
            end
        end
    end

    // Reload bytes take the live count on a capture edge
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_c_reload_reg <= `TCB_RST_WORD;
            cap_event_reg <= 1'b0;
        end else begin
            cap_event_reg <= cap_fall && timer_c_control_reg[`TCB_C_CAP_EN];
            if (cap_fall && timer_c_control_reg[`TCB_C_CAP_EN]) begin
                timer_c_reload_reg <= timer_c_count_reg;
            end
        end
    end

    // ==========================================================
    // Control byte: software write, then hardware sets on top
    always_comb begin
        ctrl_sw = timer_c_control_reg;
        if (wr_ctrl) begin
            ctrl_sw = sfr_req_i.wdata;
        end else if (bit_req_i.wr && bit_sel) begin
            ctrl_sw[bit_req_i.bit_addr[2:0]] = bit_req_i.wdata;
        end
        ctrl_sw[`TCB_C_RSVD] = 1'b0;
        timer_c_control_next = ctrl_sw;
        timer_c_control_next[`TCB_C_HIGH_OVF] = ctrl_sw[`TCB_C_HIGH_OVF] || high_wrap;
        timer_c_control_next[`TCB_C_LOW_OVF] = ctrl_sw[`TCB_C_LOW_OVF] || low_wrap;
    end

    // Control byte store
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_c_control_reg <= `TCB_RST_BYTE;
        end else begin
            timer_c_control_reg <= timer_c_control_next;
        end
    end

    // ==========================================================
    // Interrupt request, held by the high flag or by the low flag with its enable, pulsed by a capture
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_c_irq_o <= 1'b0;
        end else begin
            timer_c_irq_o <= timer_c_int_enable_i
                && (timer_c_control_next[`TCB_C_HIGH_OVF]
                || (timer_c_control_next[`TCB_C_LOW_OVF]
                && timer_c_control_next[`TCB_C_LOW_IE])
                || (cap_fall && timer_c_control_reg[`TCB_C_CAP_EN]));
        end
    end

    // ==========================================================
    // Read path, live values captured on the read strobe
    always_comb begin
        unique case (sfr_req_i.addr)
            `TCB_ADDR_B_LOW: rd_mux = timer_b_count_low_reg;
            `TCB_ADDR_A_HIGH: rd_mux = timer_a_count_high_reg;
            `TCB_ADDR_B_HIGH: rd_mux = timer_b_count_high_reg;
            `TCB_ADDR_C_CTRL: rd_mux = timer_c_control_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sfr_rdata_reg <= 8'h00;
            bit_rdata_reg <= 1'b0;
        end else begin
            if (sfr_req_i.rd) begin
                sfr_rdata_reg <= rd_mux;
            end
            if (bit_req_i.rd) begin
                bit_rdata_reg <= bit_sel && timer_c_control_reg[bit_req_i.bit_addr[2:0]];
            end
        end
    end

    // Outputs
    assign sfr_rdata_o = sfr_rdata_reg;
    assign bit_rdata_o = bit_rdata_reg;
    assign timer_a_count_high_o = timer_a_count_high_reg;
    assign timer_b_count_o = {timer_b_count_high_reg, timer_b_count_low_reg};
    assign timer_c_count_o = timer_c_count_reg;
    assign timer_c_reload_o = timer_c_reload_reg;
    assign timer_c_control_o = timer_c_control_reg;

    // ==========================================================
    // Checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    b_low_write_a: assert property (wr_b_low |=> timer_b_count_o[7:0] == $past(sfr_req_i.wdata))
        else $error("timer B low byte did not load");
    a_high_write_a: assert property (wr_a_high |=> timer_a_count_high_o == $past(sfr_req_i.wdata))
        else $error("timer A high byte did not load");
    b_high_write_a: assert property (wr_b_high |=> timer_b_count_o[15:8] == $past(sfr_req_i.wdata))
        else $error("timer B high byte did not load");
    ctrl_bit_write_a: assert property (bit_req_i.wr && bit_sel && !sfr_req_i.wr
        && bit_req_i.bit_addr[2:0] inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5}
        |=> timer_c_control_o[$past(bit_req_i.bit_addr[2:0])] == $past(bit_req_i.wdata))
        else $error("control bit write lost");
    high_flag_set_a: assert property (high_wrap |=> timer_c_control_o[`TCB_C_HIGH_OVF])
        else $error("high overflow flag not set");
    high_flag_hold_a: assert property (timer_c_control_o[`TCB_C_HIGH_OVF] && !wr_ctrl
        && !(bit_req_i.wr && bit_sel) |=> timer_c_control_o[`TCB_C_HIGH_OVF])
        else $error("high overflow flag cleared by hardware");
    low_flag_set_a: assert property (low_wrap |=> timer_c_control_o[`TCB_C_LOW_OVF])
        else $error("low overflow flag not set");
    low_irq_a: assert property (low_wrap && timer_c_int_enable_i
        && timer_c_control_next[`TCB_C_LOW_IE] |=> timer_c_irq_o)
        else $error("low overflow did not interrupt");
    capture_copy_a: assert property (cap_fall && timer_c_control_o[`TCB_C_CAP_EN]
        |=> timer_c_reload_o == $past(timer_c_count_o))
        else $error("capture did not copy count");
    capture_irq_a: assert property (cap_fall && timer_c_control_o[`TCB_C_CAP_EN]
        && timer_c_int_enable_i |=> timer_c_irq_o)
        else $error("capture did not interrupt");
    capture_pulse_a: assert property (cap_event_reg |=> !cap_event_reg)
        else $error("capture event longer than one cycle");
    split_low_runs_a: assert property (split && !run && timer_c_tick_i
        && timer_c_count_o[7:0] != `TCB_BYTE_MAX
        |=> timer_c_count_o == {$past(timer_c_count_o[15:8]), $past(timer_c_count_o[7:0]) + 8'h01})
        else $error("split low byte did not count alone");
    read_live_a: assert property (sfr_req_i.rd && sfr_req_i.addr == `TCB_ADDR_B_LOW
        |=> sfr_rdata_o == $past(timer_b_count_o[7:0]))
        else $error("read did not return live count");

endmodule
